// *** hdl/irap_cfg.svh ***
`ifndef IRAP_CFG_SVH
`define IRAP_CFG_SVH

// =====================================================
// Primary register byte offsets
`define IRAP_OFS_EWA     6'h02
`define IRAP_OFS_EXT_WRITE_DATA_UPPER    6'h04
`define IRAP_OFS_EXT_WRITE_DATA_LOWER    6'h06
`define IRAP_OFS_EXT_WRITE_COMMAND_STATE    6'h08
`define IRAP_OFS_ERA     6'h0A
`define IRAP_OFS_EXT_READ_COMMAND_STATE    6'h0C
`define IRAP_OFS_EXT_READ_DATA_UPPER    6'h0E
`define IRAP_OFS_EXT_READ_DATA_LOWER    6'h10
`define IRAP_OFS_DEVCTL  6'h1E
`define IRAP_OFS_ANGLE   6'h20
// Command/status fields and extended config locations
`define IRAP_GO_BIT      15
`define IRAP_DONE_BIT    0
`define IRAP_REFUSE_BIT  1
`define IRAP_CFG_IDX     6'h19
`define IRAP_LOCK_BIT    0
`define IRAP_DM_BIT      1
// =====================================================
// Link timing
`define IRAP_FRAME_BITS  16
`define IRAP_CLK_MHZ     40
`define IRAP_CS_IDLE_NS  200
`define IRAP_CS_IDLE_CYC ((`IRAP_CS_IDLE_NS*`IRAP_CLK_MHZ+999)/1000)
`define IRAP_SCLK_HALF   8
`define IRAP_MAN_HALF    16
// Host APB map
`define IRAP_APB_CMD     8'h00
`define IRAP_APB_STAT    8'h04
`endif

// *** hdl/irap_pkg.sv ***
package irap_pkg;
  typedef logic [15:0] irap_word_t;
  typedef logic [5:0]  irap_addr_t;
  typedef enum {MRX_IDLE, MRX_BITS} irap_mrx_e;
  typedef enum {HS_IDLE, HS_SPI, HS_GAP, HS_MTX, HS_MRX}
    irap_hst_e;
endpackage : irap_pkg

// *** hdl/irap_link_if.sv ***
interface irap_link_if;
  logic sclk;
  logic chip_select_n;
  logic mosi;
  logic miso;
  logic supply_code;
  logic pwm_code;
  modport device (
    input  sclk, chip_select_n, mosi, supply_code,
    output miso, pwm_code
  );
  modport host (
    output sclk, chip_select_n, mosi, supply_code,
    input  miso, pwm_code
  );
endinterface : irap_link_if

// *** hdl/irap_device.sv ***
`include "irap_cfg.svh"
module irap_device #(
  parameter int EXT_DEPTH = 64,
  parameter int MAN_HALF  = `IRAP_MAN_HALF
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Link to the host
  irap_link_if.device            lnk,
  // User side
  input  wire irap_pkg::irap_word_t angle_in,
  output logic [15:0]            device_control
);
  import irap_pkg::*;
  localparam int IW = $clog2(EXT_DEPTH);
  localparam logic [4:0] LAST_BIT = 5'(`IRAP_FRAME_BITS - 1);

  function automatic logic is_reg(input irap_addr_t a,
                                  input irap_addr_t o);
    return a[5:1] == o[5:1];
  endfunction : is_reg

  // Even byte address carries the upper byte.
  function automatic irap_word_t put_byte(input irap_word_t old,
                                          input logic odd,
                                          input logic [7:0] b);
    return odd ? {old[15:8], b} : {b, old[7:0]};
  endfunction : put_byte

  // =====================================================
  // Pin synchronisers
  logic [2:0] sclk_s;
  logic [2:0] csn_s;
  logic [1:0] mosi_s;
  logic [2:0] man_s;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_s <= 3'h7;
      csn_s  <= 3'h7;
      mosi_s <= 2'h0;
      man_s  <= 3'h7;
    end else begin
      sclk_s <= {sclk_s[1:0], lnk.sclk};
      csn_s  <= {csn_s[1:0], lnk.chip_select_n};
      mosi_s <= {mosi_s[0], lnk.mosi};
      man_s  <= {man_s[1:0], lnk.supply_code};
    end
  end
  logic spi_rise, spi_fall, cs_act, cs_fall, cs_rise, man_fall;
  assign spi_rise = sclk_s[1] & ~sclk_s[2];
  assign spi_fall = ~sclk_s[1] & sclk_s[2];
  assign cs_act   = ~csn_s[1];
  assign cs_fall  = ~csn_s[1] & csn_s[2];
  assign cs_rise  = csn_s[1] & ~csn_s[2];
  assign man_fall = ~man_s[1] & man_s[2];

  // =====================================================
  // SPI receive: mode 3, sample on rising SCLK
  irap_word_t spi_in_reg;
  logic [4:0] spi_cnt_reg;
  logic       spi_valid;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      spi_in_reg  <= 16'h0000;
      spi_cnt_reg <= 5'h00;
    end else if (cs_fall) begin
      spi_cnt_reg <= 5'h00;
    end else if (cs_act && spi_rise) begin
      // Bits past the sixteenth are check bits and are not kept.
      if (spi_cnt_reg <= LAST_BIT)
        spi_in_reg <= {spi_in_reg[14:0], mosi_s[1]};
      if (spi_cnt_reg != 5'h1F)
        spi_cnt_reg <= spi_cnt_reg + 5'h01;
    end
  end
  assign spi_valid = cs_rise & (spi_cnt_reg > LAST_BIT);

  // =====================================================
  // Manchester receive: first half of each bit is its value
  irap_mrx_e  mrx_state;
  logic [15:0] mrx_ph_reg;
  logic [4:0]  mrx_bit_reg;
  irap_word_t  man_in_reg;
  logic        man_done_reg;
  logic        man_pend_reg;
  logic [31:0] ext_mem [EXT_DEPTH];
  logic        man_disable, wr_lock;
  assign man_disable = ext_mem[`IRAP_CFG_IDX][`IRAP_DM_BIT];
  assign wr_lock     = ext_mem[`IRAP_CFG_IDX][`IRAP_LOCK_BIT];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mrx_state    <= MRX_IDLE;
      mrx_ph_reg   <= 16'h0000;
      mrx_bit_reg  <= 5'h00;
      man_in_reg   <= 16'h0000;
      man_done_reg <= 1'b0;
    end else begin
      man_done_reg <= 1'b0;
      case (mrx_state)
        MRX_IDLE: begin
          if (man_fall) begin
            mrx_state   <= MRX_BITS;
            mrx_ph_reg  <= 16'h0001;
            mrx_bit_reg <= 5'h00;
          end
        end
        MRX_BITS: begin
          mrx_ph_reg <= mrx_ph_reg + 16'h0001;
          if (mrx_ph_reg == 16'(MAN_HALF / 2))
            man_in_reg <= {man_in_reg[14:0], man_s[1]};
          if (mrx_ph_reg == 16'(2 * MAN_HALF - 1)) begin
            mrx_ph_reg  <= 16'h0000;
            mrx_bit_reg <= mrx_bit_reg + 5'h01;
            if (mrx_bit_reg == LAST_BIT) begin
              mrx_state    <= MRX_IDLE;
              man_done_reg <= 1'b1;
            end
          end
        end
        default: mrx_state <= MRX_IDLE;
      endcase
    end
  end

  // SPI wins a tie; a Manchester frame waits one cycle.
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      man_pend_reg <= 1'b0;
    else if (man_done_reg && !man_disable)
      man_pend_reg <= 1'b1;
    else if (!spi_valid)
      man_pend_reg <= 1'b0;
  end

  // =====================================================
  // Frame decode shared by both paths
  logic       frm_go, frm_man, wr, rd;
  irap_word_t frm;
  irap_addr_t fa;
  assign frm_go  = spi_valid | man_pend_reg;
  assign frm_man = ~spi_valid;
  assign frm     = spi_valid ? spi_in_reg : man_in_reg;
  assign fa      = frm[13:8];
  assign wr      = frm_go & ~frm[15] & frm[14];
  assign rd      = frm_go & ~frm[15] & ~frm[14];

  logic ext_wgo, ext_rgo;
  assign ext_wgo = wr & is_reg(fa, `IRAP_OFS_EXT_WRITE_COMMAND_STATE) & ~fa[0]
                 & frm[`IRAP_GO_BIT - 8];
  assign ext_rgo = wr & is_reg(fa, `IRAP_OFS_EXT_READ_COMMAND_STATE) & ~fa[0]
                 & frm[`IRAP_GO_BIT - 8];

  // =====================================================
  // Primary registers
  irap_word_t ewa_reg, ext_write_data_upper_reg, ext_write_data_lower_reg, era_reg;
  irap_word_t ext_read_data_upper_reg, ext_read_data_lower_reg, devctl_reg;
  logic [1:0] ext_write_command_state_reg, ext_read_command_state_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ewa_reg    <= 16'h0000;
      ext_write_data_upper_reg   <= 16'h0000;
      ext_write_data_lower_reg   <= 16'h0000;
      era_reg    <= 16'h0000;
      devctl_reg <= 16'h0000;
    end else if (wr) begin
      if (is_reg(fa, `IRAP_OFS_EWA))
        ewa_reg <= put_byte(ewa_reg, fa[0], frm[7:0]);
      if (is_reg(fa, `IRAP_OFS_EXT_WRITE_DATA_UPPER))
        ext_write_data_upper_reg <= put_byte(ext_write_data_upper_reg, fa[0], frm[7:0]);
      if (is_reg(fa, `IRAP_OFS_EXT_WRITE_DATA_LOWER))
        ext_write_data_lower_reg <= put_byte(ext_write_data_lower_reg, fa[0], frm[7:0]);
      if (is_reg(fa, `IRAP_OFS_ERA))
        era_reg <= put_byte(era_reg, fa[0], frm[7:0]);
      if (is_reg(fa, `IRAP_OFS_DEVCTL))
        devctl_reg <= put_byte(devctl_reg, fa[0], frm[7:0]);
    end
  end
  assign device_control = devctl_reg;

  // Extended write: locked writes leave memory untouched.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_write_command_state_reg <= 2'h0;
      for (int i = 0; i < EXT_DEPTH; i++)
        ext_mem[i] <= 32'h00000000;
    end else if (ext_wgo) begin
      if (wr_lock) begin
        ext_write_command_state_reg <= 2'h3;
      end else begin
        ext_mem[ewa_reg[IW-1:0]] <= {ext_write_data_upper_reg, ext_write_data_lower_reg};
        ext_write_command_state_reg <= 2'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_read_command_state_reg <= 2'h0;
      ext_read_data_upper_reg <= 16'h0000;
      ext_read_data_lower_reg <= 16'h0000;
    end else if (ext_rgo) begin
      ext_read_data_upper_reg <= ext_mem[era_reg[IW-1:0]][31:16];
      ext_read_data_lower_reg <= ext_mem[era_reg[IW-1:0]][15:0];
      ext_read_command_state_reg <= 2'h1;
    end
  end

  irap_word_t rd_word;
  always_comb begin
    rd_word = 16'h0000;
    case (fa[5:1])
      `IRAP_OFS_EWA    >> 1: rd_word = ewa_reg;
      `IRAP_OFS_EXT_WRITE_DATA_UPPER   >> 1: rd_word = ext_write_data_upper_reg;
      `IRAP_OFS_EXT_WRITE_DATA_LOWER   >> 1: rd_word = ext_write_data_lower_reg;
      `IRAP_OFS_EXT_WRITE_COMMAND_STATE   >> 1: rd_word = {14'h0000, ext_write_command_state_reg};
      `IRAP_OFS_ERA    >> 1: rd_word = era_reg;
      `IRAP_OFS_EXT_READ_COMMAND_STATE   >> 1: rd_word = {14'h0000, ext_read_command_state_reg};
      `IRAP_OFS_EXT_READ_DATA_UPPER   >> 1: rd_word = ext_read_data_upper_reg;
      `IRAP_OFS_EXT_READ_DATA_LOWER   >> 1: rd_word = ext_read_data_lower_reg;
      `IRAP_OFS_DEVCTL >> 1: rd_word = devctl_reg;
      `IRAP_OFS_ANGLE  >> 1: rd_word = angle_in;
      default:               rd_word = 16'h0000;
    endcase
  end

  // =====================================================
  // Answers: SPI returns in the next frame, Manchester at once
  irap_word_t resp_reg, miso_sh_reg, tx_sh_reg;
  logic       tx_act_reg, pwm_reg, tx_bit;
  logic [15:0] tx_ph_reg;
  logic [4:0]  tx_bit_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      resp_reg <= 16'h0000;
    else if (rd && !frm_man)
      resp_reg <= rd_word;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      miso_sh_reg <= 16'h0000;
    else if (cs_fall)
      miso_sh_reg <= resp_reg;
    else if (cs_act && spi_fall && spi_cnt_reg != 5'h00)
      // The first fall only opens the frame; bit 15 must stand to rise 1.
      miso_sh_reg <= {miso_sh_reg[14:0], 1'b0};
  end
  assign lnk.miso = miso_sh_reg[15];

  // A leading zero bit lets the host find the answer whatever bit 15 is.
  assign tx_bit = (tx_bit_reg == 5'h00) ? 1'b0 : tx_sh_reg[15];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_act_reg <= 1'b0;
      tx_ph_reg  <= 16'h0000;
      tx_bit_reg <= 5'h00;
      tx_sh_reg  <= 16'h0000;
      pwm_reg    <= 1'b1;
    end else if (rd && frm_man) begin
      tx_act_reg <= 1'b1;
      tx_ph_reg  <= 16'h0000;
      tx_bit_reg <= 5'h00;
      tx_sh_reg  <= rd_word;
      pwm_reg    <= 1'b1;
    end else if (tx_act_reg) begin
      pwm_reg   <= (tx_ph_reg < 16'(MAN_HALF)) ? tx_bit : ~tx_bit;
      tx_ph_reg <= tx_ph_reg + 16'h0001;
      if (tx_ph_reg == 16'(2 * MAN_HALF - 1)) begin
        tx_ph_reg  <= 16'h0000;
        if (tx_bit_reg != 5'h00)
          tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
        tx_bit_reg <= tx_bit_reg + 5'h01;
        if (tx_bit_reg == LAST_BIT + 5'h01)
          tx_act_reg <= 1'b0;
      end
    end else begin
      pwm_reg <= 1'b1;
    end
  end
  assign lnk.pwm_code = pwm_reg;
endmodule : irap_device

// *** hdl/irap_host.sv ***
`include "irap_cfg.svh"
module irap_host #(
  parameter int SCLK_HALF = `IRAP_SCLK_HALF,
  parameter int MAN_HALF  = `IRAP_MAN_HALF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link to the device
  irap_link_if.host        lnk
);
  import irap_pkg::*;
  localparam logic [4:0] NBITS = 5'(`IRAP_FRAME_BITS);

  // =====================================================
  // Input synchronisers
  logic [1:0] miso_s;
  logic [2:0] pwm_s;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      miso_s <= 2'h0;
      pwm_s  <= 3'h7;
    end else begin
      miso_s <= {miso_s[0], lnk.miso};
      pwm_s  <= {pwm_s[1:0], lnk.pwm_code};
    end
  end

  // =====================================================
  // APB registers: no wait states; pready is high in the first access cycle
  irap_hst_e  st;
  logic [16:0] cmd_reg;
  irap_word_t rdata_reg;
  logic       noans_reg, busy, pready_reg, start;
  logic [31:0] prdata_reg;
  assign busy  = (st != HS_IDLE);
  assign start = psel & penable & pready_reg & pwrite & ~busy
               & (paddr == `IRAP_APB_CMD);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      cmd_reg    <= 17'h00000;
    end else begin
      pready_reg <= psel & ~penable;
      prdata_reg <= 32'h00000000;
      if (psel && !penable && !pwrite && paddr == `IRAP_APB_CMD)
        prdata_reg <= {15'h0000, cmd_reg};
      if (psel && !penable && !pwrite && paddr == `IRAP_APB_STAT)
        prdata_reg <= {rdata_reg, 14'h0000, noans_reg, busy};
      if (start)
        cmd_reg <= pwdata[16:0];
    end
  end
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = 1'b0;

  // =====================================================
  // Link engine
  irap_word_t word, sh_reg, rx_reg;
  logic [15:0] tmr_reg;
  logic [4:0]  bit_reg;
  logic        sclk_reg, csn_reg, mosi_reg, man_reg, again_reg;
  logic        is_rd;
  // Leading zero, write flag, six address bits, data byte.
  assign word  = {1'b0, cmd_reg[14:0]};
  assign is_rd = ~cmd_reg[14];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= HS_IDLE;
      {sclk_reg, csn_reg, mosi_reg, man_reg} <= 4'hF;
      {sh_reg, rx_reg, rdata_reg} <= 48'h0;
      {tmr_reg, bit_reg} <= 21'h0;
      {again_reg, noans_reg} <= 2'h0;
    end else begin
      case (st)
        HS_IDLE: if (start) begin
          sh_reg    <= {1'b0, pwdata[14:0]};
          bit_reg   <= 5'h00;
          tmr_reg   <= 16'(SCLK_HALF - 1);
          again_reg <= 1'b0;
          noans_reg <= 1'b0;
          if (pwdata[16]) begin
            st <= HS_MTX;
            tmr_reg <= 16'h0000;
          end else begin
            st       <= HS_SPI;
            csn_reg  <= 1'b0;
            mosi_reg <= 1'b0;
          end
        end
        HS_SPI: if (tmr_reg != 16'h0000) begin
          tmr_reg <= tmr_reg - 16'h0001;
        end else begin
          tmr_reg <= 16'(SCLK_HALF - 1);
          if (sclk_reg && bit_reg == NBITS) begin
            csn_reg <= 1'b1;
            st      <= HS_GAP;
            tmr_reg <= 16'(`IRAP_CS_IDLE_CYC);
          end else if (sclk_reg) begin
            sclk_reg <= 1'b0;
            mosi_reg <= sh_reg[15];
            sh_reg   <= {sh_reg[14:0], 1'b0};
          end else begin
            sclk_reg <= 1'b1;
            rx_reg   <= {rx_reg[14:0], miso_s[1]};
            bit_reg  <= bit_reg + 5'h01;
          end
        end
        HS_GAP: if (tmr_reg != 16'h0000) begin
          // Back to idle high so the next frame opens with a clean fall.
          man_reg <= 1'b1;
          tmr_reg <= tmr_reg - 16'h0001;
        end else if (is_rd && !cmd_reg[16] && !again_reg) begin
          // The answer comes back in a repeated frame.
          again_reg <= 1'b1;
          st        <= HS_SPI;
          csn_reg   <= 1'b0;
          sh_reg    <= word;
          bit_reg   <= 5'h00;
          tmr_reg   <= 16'(SCLK_HALF - 1);
        end else begin
          if (is_rd && !noans_reg)
            rdata_reg <= rx_reg;
          st <= HS_IDLE;
        end
        HS_MTX: begin
          man_reg <= (tmr_reg < 16'(MAN_HALF)) ? sh_reg[15]
                                               : ~sh_reg[15];
          tmr_reg <= tmr_reg + 16'h0001;
          if (tmr_reg == 16'(2 * MAN_HALF - 1)) begin
            tmr_reg <= 16'h0000;
            sh_reg  <= {sh_reg[14:0], 1'b0};
            bit_reg <= bit_reg + 5'h01;
            if (bit_reg == NBITS - 5'h01) begin
              st      <= is_rd ? HS_MRX : HS_GAP;
              tmr_reg <= 16'(4 * MAN_HALF);
              bit_reg <= 5'h00;
            end
          end
        end
        HS_MRX: begin
          man_reg <= 1'b1;
          if (!again_reg) begin
            // A disabled device never answers; give up after a wait.
            tmr_reg <= tmr_reg - 16'h0001;
            if (!pwm_s[1] && pwm_s[2]) begin
              again_reg <= 1'b1;
              tmr_reg   <= 16'h0001;
            end else if (tmr_reg == 16'h0000) begin
              noans_reg <= 1'b1;
              st        <= HS_IDLE;
            end
          end else begin
            tmr_reg <= tmr_reg + 16'h0001;
            if (tmr_reg == 16'(MAN_HALF / 2))
              rx_reg <= {rx_reg[14:0], pwm_s[1]};
            if (tmr_reg == 16'(2 * MAN_HALF - 1)) begin
              tmr_reg <= 16'h0000;
              bit_reg <= bit_reg + 5'h01;
              // Start bit plus sixteen; the start bit drops off the top.
              if (bit_reg == NBITS) begin
                st      <= HS_GAP;
                tmr_reg <= 16'(4 * MAN_HALF);
              end
            end
          end
        end
        default: st <= HS_IDLE;
      endcase
    end
  end
  assign lnk.sclk          = sclk_reg;
  assign lnk.chip_select_n = csn_reg;
  assign lnk.mosi          = mosi_reg;
  assign lnk.supply_code   = man_reg;
endmodule : irap_host

// *** test/irap_monitor.sv ***
module irap_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link wires
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic supply_code,
  input wire logic pwm_code
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ==========================================================
  // Frame bookkeeping
  // Rises are counted on the wire so a short or long frame shows up.
  logic       sclk_reg;
  logic [5:0] rise_cnt_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) sclk_reg <= 1'b1;
    else sclk_reg <= sclk;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) rise_cnt_reg <= 6'h00;
    else if (chip_select_n) rise_cnt_reg <= 6'h00;
    else if (sclk && !sclk_reg) rise_cnt_reg <= rise_cnt_reg + 6'h01;
  end

  // ==========================================================
  // Wire checks
  sequence s_open_hold;
    sclk[*6];
  endsequence
  sequence s_low_half;
    !sclk[*6];
  endsequence

  a_sclk_idle_high: assert property (chip_select_n |-> sclk)
    else $error("sclk low outside a frame");
  a_open_hold: assert property ($fell(chip_select_n) |-> s_open_hold)
    else $error("sclk fell too soon after select");
  a_sclk_low_len: assert property ($fell(sclk) |-> s_low_half)
    else $error("sclk low half too short");
  a_cs_idle_gap: assert property ($rose(chip_select_n) |-> chip_select_n[*8])
    else $error("select idle gap too short");
  a_mosi_hold: assert property ((!chip_select_n && $rose(sclk))
    |=> $stable(mosi)[*5])
    else $error("mosi moved while sclk high");
  a_first_bit_zero: assert property ((!chip_select_n && sclk && !sclk_reg
    && rise_cnt_reg == 6'h00) |-> !mosi)
    else $error("frame does not open with zero");
  a_frame_bits: assert property ($rose(chip_select_n)
    |-> rise_cnt_reg == 6'h10)
    else $error("frame bit count wrong");
  a_miso_hold: assert property ((!chip_select_n && $rose(sclk))
    |=> $stable(miso)[*4])
    else $error("miso moved while sclk high");
  a_supply_half: assert property ($changed(supply_code)
    |=> $stable(supply_code)[*7])
    else $error("supply half bit too short");
  a_pwm_half: assert property ($changed(pwm_code)
    |=> $stable(pwm_code)[*7])
    else $error("pwm half bit too short");
endmodule : irap_monitor

// *** test/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irap_pkg::*;

  // ==========================================================
  // Signals and design
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  irap_word_t  angle_in;
  logic [15:0] device_control;
  int          miscompares;
  int          checks;
  logic [16:0] exp_q[$];
  logic [16:0] msk_q[$];
  logic [15:0] ctl_q[$];
  logic [16:0] res;
  logic        res_vld;
  logic [15:0] ctl_seen;
  logic [15:0] ctl_val;
  logic [31:0] ext_val[2];
  logic [5:0]  ext_idx[2];
  logic [31:0] r;

  irap_link_if lnk_if ();
  irap_host #(.SCLK_HALF(6), .MAN_HALF(8)) irap_host_inst (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lnk_if));
  irap_device #(.EXT_DEPTH(64), .MAN_HALF(8)) irap_device_inst (
    .clk(clk), .reset(reset), .lnk(lnk_if), .angle_in(angle_in),
    .device_control(device_control));
  irap_monitor irap_monitor_inst (
    .clk(clk), .reset(reset), .sclk(lnk_if.sclk),
    .chip_select_n(lnk_if.chip_select_n), .mosi(lnk_if.mosi),
    .miso(lnk_if.miso), .supply_code(lnk_if.supply_code),
    .pwm_code(lnk_if.pwm_code));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // Checking
  task automatic end_sim;
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic cmp_word(input logic [16:0] got);
    logic [16:0] e;
    logic [16:0] m;
    checks++;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1FFFF;
    m = (msk_q.size() > 0) ? msk_q.pop_front() : 17'h00000;
    if ((got & m) !== e) begin
      miscompares++;
      $display("BAD %0t read %h expected %h", $time, got & m, e);
    end
  endtask : cmp_word

  task automatic cmp_ctl(input logic [15:0] got);
    logic [15:0] e;
    checks++;
    e = (ctl_q.size() > 0) ? ctl_q.pop_front() : ~got;
    if (got !== e) begin
      miscompares++;
      $display("BAD %0t control %h expected %h", $time, got, e);
    end
  endtask : cmp_ctl

  // Sampled on the falling edge so register updates have landed.
  always @(negedge clk) begin
    if (res_vld) cmp_word(res);
    if (device_control !== ctl_seen) begin
      cmp_ctl(device_control);
      ctl_seen = device_control;
    end
  end

  // ==========================================================
  // Drivers
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    logic ok;
    ok = 1'b0;
    q = 32'h0000_0000;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    while (!ok) begin
      @(posedge clk);
      ok = (pready === 1'b1);
      q = prdata;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Busy polling has no bound of its own; the watchdog cuts a hang.
  task automatic xfer(input logic man, input logic wr, input logic [5:0] a,
                      input logic [7:0] d, output logic [31:0] q);
    apb(1'b1, 8'h00, {15'h0000, man, 1'b0, wr, a, d}, q);
    do begin
      apb(1'b0, 8'h04, 32'h0000_0000, q);
    end while (q[0] !== 1'b0);
  endtask : xfer

  task automatic wr16(input logic man, input logic [5:0] a,
                      input logic [15:0] v);
    logic [31:0] q;
    xfer(man, 1'b1, a, v[15:8], q);
    xfer(man, 1'b1, a + 6'h01, v[7:0], q);
  endtask : wr16

  task automatic rd(input logic man, input logic [5:0] a,
                    input logic [16:0] e, input logic [16:0] m);
    logic [31:0] q;
    exp_q.push_back(e);
    msk_q.push_back(m);
    xfer(man, 1'b0, a, 8'h00, q);
    res <= {q[1], q[31:16]};
    res_vld <= 1'b1;
    @(posedge clk);
    res_vld <= 1'b0;
  endtask : rd

  task automatic ext_wr(input logic man, input logic [5:0] i,
                        input logic [31:0] v);
    logic [31:0] q;
    wr16(man, 6'h02, {10'h000, i});
    wr16(man, 6'h04, v[31:16]);
    wr16(man, 6'h06, v[15:0]);
    xfer(man, 1'b1, 6'h08, 8'h80, q);
  endtask : ext_wr

  task automatic ext_rd(input logic man, input logic [5:0] i,
                        input logic [31:0] v);
    logic [31:0] q;
    wr16(man, 6'h0A, {10'h000, i});
    xfer(man, 1'b1, 6'h0C, 8'h80, q);
    rd(man, 6'h0C, 17'h00001, 17'h10001);
    rd(man, 6'h0E, {1'b0, v[31:16]}, 17'h1FFFF);
    rd(man, 6'h10, {1'b0, v[15:0]}, 17'h1FFFF);
  endtask : ext_rd

  task automatic ctl_step(input logic man);
    logic [15:0] nv;
    r = $urandom() | 32'h0000_0101;
    nv = ctl_val ^ r[15:0];
    ctl_q.push_back({nv[15:8], ctl_val[7:0]});
    ctl_q.push_back(nv);
    wr16(man, 6'h1E, nv);
    ctl_val = nv;
    rd(man, 6'h1E, {1'b0, nv}, 17'h1FFFF);
  endtask : ctl_step

  // ==========================================================
  // Watchdog and main sequence
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, res_vld} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    angle_in = 16'h0000;
    res = 17'h00000;
    ctl_seen = 16'h0000;
    ctl_val = 16'h0000;
    miscompares = 0;
    checks = 0;
    void'($urandom(32'hE4CF));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      ctl_step(m[0]);
      r = $urandom();
      angle_in <= r[15:0];
      rd(m[0], 6'h20, {1'b0, r[15:0]}, 17'h1FFFF);
      ext_idx[m] = 6'h20 + 6'(m);
      ext_val[m] = $urandom();
      ext_wr(m[0], ext_idx[m], ext_val[m]);
      rd(m[0], 6'h08, 17'h00001, 17'h10003);
      ext_rd(!m[0], ext_idx[m], ext_val[m]);
    end
    // Once the Manchester path is off, only SPI can set the lock.
    ext_wr(1'b0, 6'h19, 32'h0000_0002);
    rd(1'b1, 6'h1E, 17'h10000, 17'h10000);
    wr16(1'b1, 6'h1E, ~ctl_val);
    ctl_step(1'b0);
    ext_wr(1'b0, 6'h19, 32'h0000_0003);
    ext_wr(1'b0, ext_idx[0], ~ext_val[0]);
    rd(1'b0, 6'h08, 17'h00003, 17'h10003);
    ext_rd(1'b0, ext_idx[0], ext_val[0]);
    ctl_step(1'b0);
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule : tb_top
